//--- pkg/apm_params.svh
// Constants for the converter power-mode and result-coding block
// Overview of operation
// - Unipolar range gives straight binary, zero scale is the lowest code.
// - Bipolar range gives two's complement codes about half the reference.
// - Result spans 4096 codes; transitions at half-step points.
// - Power state comes from both select bits and the sleep pin level.
// - Full power-down switches off everything, reference included.
// - Partial power-down keeps only the reference powered.
// - Bits 00 with sleep high never power down.
// - Bits 00: sleep low powers down between conversions, high stays up.
// - Bits 01 between-conv down, 10 full down, 11 partial between-conv.
// - Full down, full up, and both between-conversion modes are selectable.
// - Power down on busy fall, up on start fall; start pulse at least 5 us (a shorter pulse still converts, on a settling core).
`ifndef APM_PARAMS_SVH
`define APM_PARAMS_SVH
`define APM_CODE_W 12
`define APM_CODE_MSB 11
`define APM_SEL_W 2
`define APM_SYS_CLK_MHZ 200
`define APM_WAKE_NS 5000
// Least time: round up
`define APM_WAKE_CYC ((`APM_WAKE_NS * `APM_SYS_CLK_MHZ + 999) / 1000)
`define APM_CNT_W 11
`define APM_RST_RESULT 12'h000
`define APM_RST_MODE 4'h1
`endif

//--- pkg/apm_pkg.sv
// Types of the converter power-mode block
`include "apm_params.svh"
package apm_pkg;
   typedef enum logic [3:0] {
      APM_MODE_UP     = 4'b0001,
      APM_MODE_BTW    = 4'b0010,
      APM_MODE_DOWN   = 4'b0100,
      APM_MODE_PBTW   = 4'b1000
   } apm_mode_e;
   typedef enum logic [3:0] {
      APM_ST_ON    = 4'b0001,
      APM_ST_SLEEP = 4'b0010,
      APM_ST_WAKE  = 4'b0100,
      APM_ST_CONV  = 4'b1000
   } apm_state_e;
endpackage

//--- hdl/apm_coder.sv
// Result coding: straight binary or two's complement
`timescale 1ns/1ps
`default_nettype none
`include "apm_params.svh"
module apm_coder
   import apm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Raw result
   input wire logic load,
   input wire logic bipolar,
   input wire logic [`APM_CODE_MSB:0] raw_code,
   // Coded result
   output logic [`APM_CODE_MSB:0] code_q
);
   // Raw code counts up from the bottom of the range; bipolar flips the top bit
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         code_q <= `APM_RST_RESULT;
      end else if (clk_en && load) begin
         if (bipolar) begin
            code_q <= {~raw_code[`APM_CODE_MSB], raw_code[`APM_CODE_MSB-1:0]};
         end else begin
            code_q <= raw_code;
         end
      end
   end
endmodule // apm_coder
`default_nettype wire

//--- hdl/apm_power_ctrl.sv
// Power-mode selection and sequencing of the sampling converter
`timescale 1ns/1ps
`default_nettype none
`include "apm_params.svh"
module apm_power_ctrl
   import apm_pkg::*;
(
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Control bits
   input wire logic power_sel_hi,
   input wire logic power_sel_lo,
   input wire logic bipolar,
   // Pins
   input wire logic sleep_n_pin,
   input wire logic conv_start_pin_n,
   // Conversion core
   input wire logic core_busy,
   input wire logic [`APM_CODE_MSB:0] core_code,
   output logic conv_go,
   // Power domains and status
   output logic core_pwr_on,
   output logic ref_pwr_on,
   output logic ready,
   output logic [3:0] mode_q,
   output logic [`APM_CODE_MSB:0] result_q
);
   // ==========================================================
   // Pin synchronisers
   logic [1:0] sleep_sync_q;
   logic [1:0] start_sync_q;
   logic start_prev_q;
   logic busy_prev_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleep_sync_q <= 2'h3;
         start_sync_q <= 2'h3;
      end else if (clk_en) begin
         sleep_sync_q <= {sleep_sync_q[0], sleep_n_pin};
         start_sync_q <= {start_sync_q[0], conv_start_pin_n};
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         start_prev_q <= 1'b1;
         busy_prev_q <= 1'b0;
      end else if (clk_en) begin
         start_prev_q <= start_sync_q[1];
         busy_prev_q <= core_busy;
      end
   end
   logic start_fall;
   logic start_rise;
   logic busy_fall;
   assign start_fall = start_prev_q && !start_sync_q[1];
   assign start_rise = !start_prev_q && start_sync_q[1];
   assign busy_fall = busy_prev_q && !core_busy;

   // ==========================================================
   // Mode decode
   apm_mode_e mode_d;
   always_comb begin
      unique case ({power_sel_hi, power_sel_lo})
         2'b00: mode_d = sleep_sync_q[1] ? APM_MODE_UP : APM_MODE_BTW;
         2'b01: mode_d = APM_MODE_BTW;
         2'b10: mode_d = APM_MODE_DOWN;
         2'b11: mode_d = APM_MODE_PBTW;
      endcase
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= `APM_RST_MODE;
      end else if (clk_en) begin
         mode_q <= mode_d;
      end
   end
   logic mode_up;
   logic mode_down;
   logic mode_partial;
   assign mode_up = (mode_q == APM_MODE_UP);
   assign mode_down = (mode_q == APM_MODE_DOWN);
   assign mode_partial = (mode_q == APM_MODE_PBTW);

   // ==========================================================
   // Power sequencer
   apm_state_e st_q;
   logic [`APM_CNT_W-1:0] wake_cnt_q;
   localparam logic [`APM_CNT_W-1:0] WAKE_LAST = `APM_CNT_W'(`APM_WAKE_CYC - 1);
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= APM_ST_ON;
      end else if (clk_en) begin
         unique case (st_q)
            APM_ST_ON: begin
               if (mode_down) begin
                  st_q <= APM_ST_SLEEP;
               end else if (start_rise) begin
                  st_q <= APM_ST_CONV;
               end
            end
            APM_ST_CONV: begin
               if (busy_fall && !mode_up) begin
                  st_q <= APM_ST_SLEEP;
               end else if (busy_fall) begin
                  st_q <= APM_ST_ON;
               end
            end
            APM_ST_SLEEP: begin
               if (mode_up) begin
                  st_q <= APM_ST_ON;
               end else if (start_fall && !mode_down) begin
                  st_q <= APM_ST_WAKE;
               end
            end
            APM_ST_WAKE: begin
               // Too-short start pulse still converts, just on a settling core
               if (mode_down) begin
                  st_q <= APM_ST_SLEEP;
               end else if (start_rise) begin
                  st_q <= APM_ST_CONV;
               end else if (wake_cnt_q == WAKE_LAST) begin
                  st_q <= APM_ST_ON;
               end
            end
         endcase
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         wake_cnt_q <= '0;
      end else if (clk_en) begin
         if (st_q == APM_ST_WAKE && wake_cnt_q != WAKE_LAST) begin
            wake_cnt_q <= wake_cnt_q + 1'b1;
         end else if (st_q != APM_ST_WAKE) begin
            wake_cnt_q <= '0;
         end
      end
   end
   assign conv_go = clk_en && start_rise && (st_q == APM_ST_ON || st_q == APM_ST_WAKE);
   assign core_pwr_on = (st_q != APM_ST_SLEEP);
   assign ref_pwr_on = (st_q != APM_ST_SLEEP) || mode_partial;
   assign ready = (st_q == APM_ST_ON);

   // ==========================================================
   // Result coding
   apm_coder u_coder (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .load(busy_fall),
      .bipolar(bipolar),
      .raw_code(core_code),
      .code_q(result_q)
   );

   // ==========================================================
   // Checks
   a_up_stays_on: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && mode_up && st_q != APM_ST_SLEEP |=> core_pwr_on)
      else $error("Full power-up mode dropped core power");
   a_down_all_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && mode_down && st_q == APM_ST_ON |=> !core_pwr_on && !ref_pwr_on)
      else $error("Full power-down left circuitry on");
   a_partial_ref: assert property (@(posedge sys_clk) disable iff (!rst_n)
      mode_partial |-> ref_pwr_on)
      else $error("Partial power-down lost the reference");
   a_sel_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && power_sel_hi && !power_sel_lo |=> mode_q == APM_MODE_DOWN)
      else $error("Select bits 10 did not give full power-down");
   a_sleep_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && !power_sel_hi && !power_sel_lo && !sleep_sync_q[1] |=> mode_q == APM_MODE_BTW)
      else $error("Sleep low with bits 00 not between-conversion mode");
   a_busy_sleep: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && st_q == APM_ST_CONV && busy_fall && !mode_up |=> !core_pwr_on)
      else $error("No power-down after busy fell");
   a_start_wake: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && st_q == APM_ST_SLEEP && start_fall && !mode_down && !mode_up |=> st_q == APM_ST_WAKE)
      else $error("Start falling edge did not wake");
   a_bipolar_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && busy_fall && bipolar |=> result_q == {~$past(core_code[`APM_CODE_MSB]),
                                                      $past(core_code[`APM_CODE_MSB-1:0])})
      else $error("Bipolar result not two's complement");
   a_unipolar_code: assert property (@(posedge sys_clk) disable iff (!rst_n)
      clk_en && busy_fall && !bipolar |=> result_q == $past(core_code))
      else $error("Unipolar result not straight binary");
   c_wake_conv: cover property (@(posedge sys_clk) st_q == APM_ST_WAKE ##[1:1000] st_q == APM_ST_CONV);
   c_partial: cover property (@(posedge sys_clk) mode_partial && st_q == APM_ST_SLEEP);
   c_full_down: cover property (@(posedge sys_clk) mode_down && !core_pwr_on);
   c_bipolar: cover property (@(posedge sys_clk) busy_fall && bipolar);
endmodule // apm_power_ctrl
`default_nettype wire

//--- test/apm_core_model.sv
// Behavioural conversion core behind the power-mode block
`timescale 1ns/1ps
`default_nettype none
`include "apm_params.svh"
module apm_core_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Control side
   input wire logic conv_go,
   input wire logic [`APM_CODE_MSB:0] code_in,
   // Core outputs
   output logic core_busy,
   output logic [`APM_CODE_MSB:0] core_code,
   output int go_cnt
);
   logic [3:0] cnt_q;
   logic [1:0] hold_q;
   // =====================================
   // Busy window and result hand-over
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 4'h0;
         hold_q <= 2'h0;
         go_cnt <= 0;
         core_busy <= 1'b0;
         core_code <= 12'h5a5;
      end else begin
         if (conv_go && !core_busy) begin
            core_busy <= 1'b1;
            cnt_q <= 4'h8;
            go_cnt <= go_cnt + 1;
         end else if (cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
            if (cnt_q == 4'h1) begin
               core_busy <= 1'b0;
               hold_q <= 2'h2;
            end
         end else if (hold_q != 2'h0) begin
            hold_q <= hold_q - 2'h1;
         end
         // Invalid outside the busy and hold windows, so the inverted input code shows
         core_code <= (core_busy || hold_q != 2'h0) ? code_in : ~code_in;
      end
   end
endmodule // apm_core_model
`default_nettype wire

//--- test/tb.sv
// Self-checking bench of the power-mode and coding block
`timescale 1ns/1ps
`default_nettype none
`include "apm_params.svh"
module tb;
   import apm_pkg::*;
   logic sys_clk = 1'b0, rst_n = 1'b0, sel_hi = 1'b0, sel_lo = 1'b0, bip = 1'b0, sleep_n = 1'b1, start_n = 1'b1;
   logic conv_go, core_busy, core_pwr_on, ref_pwr_on, ready;
   logic clk_en = 1'b1;
   logic [`APM_CODE_MSB:0] core_code, result_q, code_in = 12'h000;
   logic [3:0] mode_q;
   int error_cnt = 0, num_checks = 0, go_cnt, n0;
   logic [1:0] t_sel [4] = '{2'b01, 2'b11, 2'b11, 2'b00};
   logic t_slp [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
   logic t_bip [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   logic [11:0] t_raw [4] = '{12'hfff, 12'h000, 12'h7ff, 12'h5a3};
   logic [11:0] t_res [4] = '{12'hfff, 12'h800, 12'hfff, 12'h5a3};
   logic t_ref [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
   always #2.5 sys_clk = ~sys_clk;
   apm_power_ctrl u_apm_power_ctrl (.sys_clk(sys_clk), .rst_n(rst_n), .clk_en(clk_en), .power_sel_hi(sel_hi),
      .power_sel_lo(sel_lo), .bipolar(bip), .sleep_n_pin(sleep_n), .conv_start_pin_n(start_n),
      .core_busy(core_busy), .core_code(core_code), .conv_go(conv_go), .core_pwr_on(core_pwr_on),
      .ref_pwr_on(ref_pwr_on), .ready(ready), .mode_q(mode_q), .result_q(result_q));
   apm_core_model u_apm_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .conv_go(conv_go), .code_in(code_in),
      .core_busy(core_busy), .core_code(core_code), .go_cnt(go_cnt));
   // =====================================
   // Shared tasks
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("CHECK FAILED %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask
   task automatic set_mode(input logic [1:0] sel, input logic slp, input logic b);
      {sel_hi, sel_lo} = sel;
      sleep_n = slp;
      bip = b;
      cyc(5);
   endtask
   function automatic logic [3:0] exp_mode(input logic [1:0] sel, input logic slp);
      case (sel)
         2'b00: exp_mode = slp ? APM_MODE_UP : APM_MODE_BTW;
         2'b01: exp_mode = APM_MODE_BTW;
         2'b10: exp_mode = APM_MODE_DOWN;
         default: exp_mode = APM_MODE_PBTW;
      endcase
   endfunction
   // Start pulse longer than the wake time, then let the core finish
   task automatic convert(input logic [11:0] c, input bit chk_w);
      code_in = c;
      start_n = 1'b0;
      cyc(4);
      if (chk_w) chk(core_pwr_on, 1, "wake power");
      cyc(500);
      if (chk_w) chk(ready, 0, "settling");
      cyc(600);
      if (chk_w) chk(ready, 1, "ready after wake");
      start_n = 1'b1;
      cyc(30);
   endtask
   task automatic end_sim;
      $display("Errors %0d checks %0d", error_cnt, num_checks);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   // =====================================
   // Tests
   initial begin
      repeat (12) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      cyc(3);
      chk(mode_q, APM_MODE_UP, "reset mode");
      chk({core_pwr_on, ref_pwr_on, ready}, 3'b111, "reset power");
      // Enable low: a select change must not reach mode or power state
      clk_en = 1'b0;
      sel_hi = 1'b1;
      cyc(10);
      chk(mode_q, APM_MODE_UP, "frozen mode");
      chk(core_pwr_on, 1, "frozen power");
      clk_en = 1'b1;
      cyc(3);
      chk(mode_q, APM_MODE_DOWN, "mode after enable");
      for (int i = 1; i <= 8; i++) begin
         set_mode(i[2:1], i[0], 1'b0);
         chk(mode_q, exp_mode(i[2:1], i[0]), "mode table");
         if (exp_mode(i[2:1], i[0]) == APM_MODE_DOWN) chk({core_pwr_on, ref_pwr_on}, 2'b00, "full down");
         if (exp_mode(i[2:1], i[0]) == APM_MODE_UP) chk({core_pwr_on, ready}, 2'b11, "full up");
         if (exp_mode(i[2:1], i[0]) == APM_MODE_PBTW) chk(ref_pwr_on, 1, "partial ref");
      end
      set_mode(2'b10, 1'b1, 1'b0);
      n0 = go_cnt;
      start_n = 1'b0;
      cyc(20);
      start_n = 1'b1;
      cyc(20);
      chk(go_cnt - n0, 0, "start ignored in full down");
      for (int k = 0; k < 4; k++) begin
         set_mode(t_sel[k], t_slp[k], t_bip[k]);
         convert(t_raw[k], 1'b0);
         convert(t_raw[k], 1'b1);
         chk(result_q, t_res[k], "coded result");
         chk({core_pwr_on, ref_pwr_on}, {1'b0, t_ref[k]}, "down after busy fall");
      end
      // Start pulse shorter than the wake time still converts
      code_in = 12'h0f0;
      n0 = go_cnt;
      start_n = 1'b0;
      cyc(50);
      start_n = 1'b1;
      cyc(30);
      chk(go_cnt - n0, 1, "short pulse converts");
      chk(result_q, 12'h0f0, "short pulse result");
      chk(core_pwr_on, 0, "down after short pulse");
      set_mode(2'b00, 1'b1, 1'b0);
      n0 = go_cnt;
      convert(12'h123, 1'b0);
      convert(12'h123, 1'b0);
      chk(result_q, 12'h123, "full up result");
      chk(core_pwr_on, 1, "stays up after conversion");
      chk(go_cnt - n0, 2, "one conversion per start pulse");
      end_sim();
   end
   initial begin
      #150us;
      error_cnt++;
      $display("CHECK FAILED %0t watchdog expired", $time);
      end_sim();
   end
endmodule // tb
`default_nettype wire
